// [dv/cuim_host_model.sv]
// Host model that accepts queued task numbers and can stall.
`timescale 1ns/1ps
module cuim_host_model (
    input  wire logic                        mclk,
    input  wire logic                        rst_n,
    input  wire logic                        task_valid,
    input  wire logic [cuim_pkg::TASK_W-1:0] task_num,
    input  wire logic                        stall,
    output      logic                        task_ready
);
    logic [cuim_pkg::TASK_W-1:0] got[$];

    always @(posedge mclk)
    begin
        if (!rst_n)
            task_ready <= 1'b0;
        else
        begin
            if (task_valid && task_ready)
                got.push_back(task_num);
            task_ready <= !stall;
        end
    end
endmodule

// [dv/cuim_top_props.sv]
// Checker with concurrent properties on the ports of the counter interrupt mapper.
`timescale 1ns/1ps
module cuim_top_props #(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic                        mclk,
    input wire logic                        rst_n,
    input wire logic [cuim_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [cuim_pkg::DATA_W-1:0] reg_wdata,
    input wire logic                        reg_wr,
    input wire logic                        reg_rd,
    input wire logic [cuim_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [cuim_pkg::N_OUT-1:0]  output_pattern,
    input wire logic                        digital_input_zero,
    input wire logic                        digital_input_one,
    input wire logic                        irq_capable_slot,
    input wire logic                        task_valid,
    input wire logic [cuim_pkg::TASK_W-1:0] task_num,
    input wire logic                        task_ready,
    input wire logic                        global_error,
    input wire logic                        irq
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    chk_reset_quiet: assert property (disable iff (1'b0)
        !rst_n |=> !irq && !task_valid && !global_error) else $error("outputs active after reset");
    chk_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("read data outside answer cycle");
    chk_head_held: assert property (
        task_valid && !task_ready |=> task_valid && $stable(task_num)) else $error("queue head lost");
    chk_pop_only: assert property (
        $fell(task_valid) && $past(rst_n) |-> $past(task_ready)) else $error("entry vanished unread");
    chk_valid_cause: assert property (
        $rose(task_valid) && $past(rst_n, 3) |-> $past(output_pattern, 2) != $past(output_pattern, 3)
        || $past(digital_input_zero, 2) != $past(digital_input_zero, 3)
        || $past(digital_input_one, 2) != $past(digital_input_one, 3)) else $error("task without edge");
    chk_slot_gate: assert property (
        $rose(task_valid) && $past(rst_n, 3) |-> $past(irq_capable_slot, 2)) else $error("task from dead slot");
    chk_err_sticky: assert property (
        global_error && !(reg_wr && reg_addr == cuim_pkg::REG_COMMAND && reg_wdata == cuim_pkg::CMD_ERR_CLEAR)
        |=> global_error) else $error("error dropped without clear");
    chk_irq_cause: assert property (
        $rose(irq) |-> task_valid || $past(task_valid) || global_error || $past(reg_wr)) else $error("irq without cause");
endmodule

// [dv/cuim_top_tb_top.sv]
// Self-checking testbench of the counter interrupt mapper.
`timescale 1ns/1ps
module cuim_top_tb_top;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [31:0] output_pattern = 32'h0000_0000;
    logic        digital_input_zero = 1'b0;
    logic        digital_input_one = 1'b0;
    logic        irq_capable_slot = 1'b1;
    logic        task_valid;
    logic [7:0]  task_num;
    logic        task_ready;
    logic        global_error;
    logic        irq;
    logic        stall = 1'b0;
    int          failures = 0;
    int          cmp_count = 0;
    logic [7:0]  exp_q[$];

    always #5 mclk = ~mclk;

    cuim_top #(.FIFO_DEPTH(2)) dut_u (
        .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .output_pattern(output_pattern),
        .digital_input_zero(digital_input_zero), .digital_input_one(digital_input_one),
        .irq_capable_slot(irq_capable_slot), .task_valid(task_valid), .task_num(task_num),
        .task_ready(task_ready), .global_error(global_error), .irq(irq));

    cuim_host_model host_u (
        .mclk(mclk), .rst_n(rst_n), .task_valid(task_valid), .task_num(task_num), .stall(stall),
        .task_ready(task_ready));

    task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e, input string n);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        check(n, e, reg_rdata);
    endtask

    task automatic toggle(input logic [31:0] m);
        @(posedge mclk);
        output_pattern <= output_pattern ^ m;
        repeat (6) @(posedge mclk);
    endtask

    task automatic pin(input logic a, input logic b);
        @(posedge mclk);
        digital_input_zero <= a;
        digital_input_one  <= b;
        repeat (6) @(posedge mclk);
    endtask

    task automatic drain_check(input string n);
        repeat (10) @(posedge mclk);
        check({n, " count"}, 16'(exp_q.size()), 16'(host_u.got.size()));
        foreach (exp_q[i])
            check(n, {8'h00, exp_q[i]}, {8'h00, host_u.got[i]});
        exp_q.delete();
        host_u.got.delete();
    endtask

    task automatic t_reset();
        rd(cuim_pkg::REG_STATUS, 16'h0008, "status");
        rd(cuim_pkg::REG_IN_IEN, 16'h0000, "input enables");
        rd(8'h40, 16'h0000, "unmapped");
        $display("t_reset done");
    endtask

    task automatic t_outputs();
        wr(cuim_pkg::REG_OUT_OFS, 16'h0005);
        wr(cuim_pkg::REG_OUT_IEN_LO, 16'h0008);
        toggle(32'h0000_0018);
        toggle(32'h0000_0018);
        exp_q = '{8'h0B, 8'h0C};
        drain_check("output three");
        check("irq masked", 16'h0000, {15'h0000, irq});
        rd(cuim_pkg::REG_IRQ_STAT, 16'h0001, "irq status");
        wr(cuim_pkg::REG_IRQ_STAT, 16'h0001);
        wr(cuim_pkg::REG_OUT_OFS, 16'h0192);
        wr(cuim_pkg::REG_OUT_IEN_HI, 16'h8000);
        toggle(32'h8000_0000);
        toggle(32'h8000_0000);
        exp_q = '{8'hFE, 8'hFF};
        drain_check("output thirty one");
        $display("t_outputs done");
    endtask

    task automatic t_simul();
        wr(cuim_pkg::REG_OUT_OFS, 16'h0010);
        wr(cuim_pkg::REG_OUT_IEN_LO, 16'h0003);
        wr(cuim_pkg::REG_IN_OFS, 16'h0010);
        wr(cuim_pkg::REG_IN_IEN, 16'h0001);
        @(posedge mclk);
        digital_input_zero <= 1'b1;
        output_pattern     <= output_pattern ^ 32'h0000_0003;
        repeat (6) @(posedge mclk);
        toggle(32'h0000_0003);
        digital_input_zero <= 1'b0;
        exp_q = '{8'h0A, 8'h0C, 8'h0A, 8'h0B, 8'h0D};
        drain_check("simultaneous");
        check("overlap error", 16'h0000, {15'h0000, global_error});
        wr(cuim_pkg::REG_IN_IEN, 16'h0000);
        $display("t_simul done");
    endtask

    task automatic t_inputs();
        int   s;
        logic fall;
        wr(cuim_pkg::REG_OUT_IEN_LO, 16'h0000);
        wr(cuim_pkg::REG_IN_OFS, 16'h0030);
        wr(cuim_pkg::REG_IN_IEN, 16'h0001);
        for (int k = 0; k <= 16; k++)
        begin
            fall = (k >= 2) && (k <= 14) && (k % 2 == 0);
            wr(cuim_pkg::REG_IN_FUNC0, {8'h00, 4'(k / 10), 4'(k % 10)});
            pin(1'b1, 1'b0);
            s = host_u.got.size();
            pin(1'b0, 1'b0);
            check("rise task", {15'h0000, !fall}, 16'(s));
            exp_q.push_back(8'h1E);
            drain_check("input zero");
        end
        wr(cuim_pkg::REG_IN_IEN, 16'h0002);
        wr(cuim_pkg::REG_IN_OFS, 16'h0252);
        wr(cuim_pkg::REG_IN_FUNC1, 16'h0002);
        pin(1'b1, 1'b1);
        pin(1'b0, 1'b0);
        exp_q.push_back(8'hFD);
        drain_check("input one");
        wr(cuim_pkg::REG_IN_IEN, 16'h0000);
        pin(1'b0, 1'b1);
        pin(1'b0, 1'b0);
        drain_check("inputs off");
        $display("t_inputs done");
    endtask

    task automatic t_slot();
        wr(cuim_pkg::REG_OUT_IEN_LO, 16'h0001);
        irq_capable_slot <= 1'b0;
        toggle(32'h0000_0001);
        toggle(32'h0000_0001);
        drain_check("slot off");
        irq_capable_slot <= 1'b1;
        $display("t_slot done");
    endtask

    task automatic t_full();
        stall <= 1'b1;
        wr(cuim_pkg::REG_IRQ_MASK, 16'h0003);
        wr(cuim_pkg::REG_OUT_OFS, 16'h0000);
        wr(cuim_pkg::REG_OUT_IEN_LO, 16'h000F);
        toggle(32'h0000_000F);
        toggle(32'h0000_0001);
        check("global error set", 16'h0001, {15'h0000, global_error});
        check("irq raised", 16'h0001, {15'h0000, irq});
        rd(cuim_pkg::REG_STATUS, 16'h0207, "status full");
        wr(cuim_pkg::REG_COMMAND, cuim_pkg::CMD_ERR_CLEAR);
        @(posedge mclk);
        check("global error clear", 16'h0000, {15'h0000, global_error});
        stall <= 1'b0;
        exp_q = '{8'h00, 8'h02, 8'h04, 8'h06};
        drain_check("full queue");
        rd(cuim_pkg::REG_STATUS, 16'h000C, "status history");
        wr(cuim_pkg::REG_IRQ_STAT, 16'h0003);
        @(posedge mclk);
        check("irq cleared", 16'h0000, {15'h0000, irq});
        $display("t_full done");
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_outputs();
        t_simul();
        t_inputs();
        t_slot();
        t_full();
        wrap_up();
    end

    initial
    begin
        #100000;
        failures++;
        wrap_up();
    end
endmodule

bind cuim_top cuim_top_props #(.FIFO_DEPTH(FIFO_DEPTH)) chk_u (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .output_pattern(output_pattern),
    .digital_input_zero(digital_input_zero), .digital_input_one(digital_input_one),
    .irq_capable_slot(irq_capable_slot), .task_valid(task_valid), .task_num(task_num),
    .task_ready(task_ready), .global_error(global_error), .irq(irq));

// [rtl/cuim_fifo_mem.sv]
// Storage array of the task queue with registered, write-first read data.
`timescale 1ns/1ps
module cuim_fifo_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic             mclk,
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [AW-1:0]    raddr,
    output      logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem_ff [DEPTH];

    always_ff @(posedge mclk)
    begin
        if (we)
        begin
            mem_ff[waddr] <= wdata;
        end
    end

    // A word written to the address being read is passed straight through.
    always_ff @(posedge mclk)
    begin
        if (we && waddr == raddr)
        begin
            rdata <= wdata;
        end
        else
        begin
            rdata <= mem_ff[raddr];
        end
    end
endmodule

// [rtl/cuim_pkg.sv]
// Package with register map, field layout and constants of the counter interrupt mapper.
package cuim_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 16;
    localparam int          TASK_W          = 8;
    localparam int          N_OUT           = 32;
    localparam int          N_IN            = 2;
    localparam int          N_SRC           = 2 * N_OUT + N_IN;
    localparam int          SRC_W           = 7;
    localparam int          FIFO_DEPTH      = 16;
    localparam logic [7:0]  REG_OUT_OFS     = 8'h00;
    localparam logic [7:0]  REG_OUT_IEN_LO  = 8'h04;
    localparam logic [7:0]  REG_OUT_IEN_HI  = 8'h08;
    localparam logic [7:0]  REG_IN_OFS      = 8'h0C;
    localparam logic [7:0]  REG_IN_IEN      = 8'h10;
    localparam logic [7:0]  REG_IN_FUNC0    = 8'h14;
    localparam logic [7:0]  REG_IN_FUNC1    = 8'h18;
    localparam logic [7:0]  REG_COMMAND     = 8'h1C;
    localparam logic [7:0]  REG_STATUS      = 8'h20;
    localparam logic [7:0]  REG_IRQ_STAT    = 8'h24;
    localparam logic [7:0]  REG_IRQ_MASK    = 8'h28;
    localparam logic [15:0] CMD_ERR_CLEAR   = 16'hEC00;
    localparam int          ST_GLOBAL_ERR   = 0;
    localparam int          ST_QFULL_ERR    = 1;
    localparam int          ST_QFULL_HIST   = 2;
    localparam int          ST_EMPTY        = 3;
    localparam int          ST_CNT_LSB      = 8;
    localparam int          IRQ_BIT_TASK    = 0;
    localparam int          IRQ_BIT_QFULL   = 1;
    localparam int          IRQ_W           = 2;
    localparam logic [15:0] RST_WORD        = 16'h0000;
    localparam logic [1:0]  RST_IRQ         = 2'h0;
    localparam logic [4:0]  FUNC_FALL_MIN   = 5'h02;
    localparam logic [4:0]  FUNC_FALL_MAX   = 5'h0E;
    localparam logic [7:0]  BCD_HUNDRED     = 8'h64;
    localparam logic [7:0]  BCD_TEN         = 8'h0A;
endpackage

// [rtl/cuim_top.sv]
// Interrupt mapper turning output-pattern and digital-input edges into queued task numbers.
//
// Notes on behaviour
// R1 - Enabled output bit: request on each edge.
// R2 - One enable bit per output.
// R3 - Rise task offset+2O, fall offset+2O+1.
// R4 - Software keeps output offset at most 192.
// R5 - Output offset read as BCD value.
// R6 - Enabled input: request on one edge.
// R7 - Function code selects input edge polarity.
// R8 - Input enable bit0 input zero, bit1 one.
// R9 - Input interrupts disabled unless enabled.
// R10 - Input tasks offset and offset plus one.
// R11 - Software keeps input offset at most 252.
// R12 - Simultaneous requests queued, delivered in order.
// R13 - Request with full queue flags error.
// R14 - Overlapping task ranges raise no error.
// R15 - Clear command clears error, history kept.
// R16 - Global error flag set on any error.
// R17 - No interrupts when position cannot deliver.
// R18 - Output enables in two 16-bit words.
// R19 - Queue depth parameterised, eight-bit entries.
`timescale 1ns/1ps
module cuim_top #(
    parameter int FIFO_DEPTH = cuim_pkg::FIFO_DEPTH,
    parameter int FIFO_AW    = $clog2(FIFO_DEPTH)
) (
    input  wire logic                          mclk,
    input  wire logic                          rst_n,
    input  wire logic [cuim_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic [cuim_pkg::DATA_W-1:0]   reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output      logic [cuim_pkg::DATA_W-1:0]   reg_rdata,
    input  wire logic [cuim_pkg::N_OUT-1:0]    output_pattern,
    input  wire logic                          digital_input_zero,
    input  wire logic                          digital_input_one,
    input  wire logic                          irq_capable_slot,
    output      logic                          task_valid,
    output      logic [cuim_pkg::TASK_W-1:0]   task_num,
    input  wire logic                          task_ready,
    output      logic                          global_error,
    output      logic                          irq
);
    localparam logic [FIFO_AW:0] FIFO_FULL_CNT = (FIFO_AW+1)'(FIFO_DEPTH);
    localparam logic [FIFO_AW:0] CNT_ONE       = (FIFO_AW+1)'(1);
    localparam logic [FIFO_AW-1:0] PTR_ONE     = FIFO_AW'(1);

    logic [15:0]                       out_ofs_ff;
    logic [15:0]                       out_ien_lo_ff;
    logic [15:0]                       out_ien_hi_ff;
    logic [15:0]                       in_ofs_ff;
    logic [15:0]                       in_ien_ff;
    logic [15:0]                       in_func0_ff;
    logic [15:0]                       in_func1_ff;
    logic [cuim_pkg::IRQ_W-1:0]        irq_stat_ff;
    logic [cuim_pkg::IRQ_W-1:0]        irq_mask_ff;
    logic                              qfull_err_ff;
    logic                              qfull_hist_ff;
    logic [cuim_pkg::N_OUT-1:0]        pat_prev_ff;
    logic [cuim_pkg::N_IN-1:0]         din_prev_ff;
    logic [cuim_pkg::N_SRC-1:0]        pend_ff;
    logic [FIFO_AW-1:0]                wr_ptr_ff;
    logic [FIFO_AW-1:0]                rd_ptr_ff;
    logic [FIFO_AW:0]                  cnt_ff;
    logic [cuim_pkg::DATA_W-1:0]       reg_rdata_ff;

    logic [cuim_pkg::N_OUT-1:0]        out_ien;
    logic [cuim_pkg::N_IN-1:0]         din;
    logic [cuim_pkg::N_IN-1:0]         in_fall;
    logic [cuim_pkg::N_SRC-1:0]        evt;
    logic [cuim_pkg::N_SRC-1:0]        nxt_pend;
    logic                              sel_valid;
    logic [cuim_pkg::SRC_W-1:0]        sel_idx;
    logic [cuim_pkg::TASK_W-1:0]       sel_task;
    logic [cuim_pkg::TASK_W-1:0]       out_base;
    logic [cuim_pkg::TASK_W-1:0]       in_base;
    logic                              fifo_full;
    logic                              push;
    logic                              pop;
    logic                              overflow;
    logic [FIFO_AW-1:0]                nxt_rd_ptr;
    logic                              clear_cmd;

    // Converts the low three BCD digits of a word to an eight-bit binary value.
    function automatic logic [7:0] bcd_to_bin(input logic [15:0] bcd);
        logic [7:0] acc;
        acc = 8'(bcd[11:8] * cuim_pkg::BCD_HUNDRED);
        acc = acc + 8'(bcd[7:4] * cuim_pkg::BCD_TEN);
        acc = acc + 8'(bcd[3:0]);
        return acc;
    endfunction

    // Returns whether a BCD function code asks for the falling edge.
    function automatic logic func_is_falling(input logic [15:0] code);
        logic [7:0] v;
        v = bcd_to_bin(code);
        return (v >= 8'(cuim_pkg::FUNC_FALL_MIN)) && (v <= 8'(cuim_pkg::FUNC_FALL_MAX)) && !v[0];
    endfunction

    assign out_ien   = {out_ien_hi_ff, out_ien_lo_ff};  // R18
    assign din       = {digital_input_one, digital_input_zero};
    assign in_fall   = {func_is_falling(in_func1_ff), func_is_falling(in_func0_ff)};  // R7
    assign out_base  = bcd_to_bin(out_ofs_ff);  // R5
    assign in_base   = bcd_to_bin(in_ofs_ff);
    assign clear_cmd = reg_wr && reg_addr == cuim_pkg::REG_COMMAND && reg_wdata == cuim_pkg::CMD_ERR_CLEAR;

    // Edge detection; each output owns a rise slot and a fall slot.
    always_comb
    begin
        evt = '0;
        for (int o = 0; o < cuim_pkg::N_OUT; o++)
        begin
            evt[2*o]   = out_ien[o] && output_pattern[o] && !pat_prev_ff[o];  // R1 R2
            evt[2*o+1] = out_ien[o] && !output_pattern[o] && pat_prev_ff[o];  // R1 R2
        end
        for (int i = 0; i < cuim_pkg::N_IN; i++)
        begin
            evt[2*cuim_pkg::N_OUT+i] = in_ien_ff[i] &&
                (in_fall[i] ? (!din[i] && din_prev_ff[i]) : (din[i] && !din_prev_ff[i]));  // R6 R8 R9
        end
        if (!irq_capable_slot)
        begin
            evt = '0;  // R17
        end
    end

    // Lowest pending source goes first, so simultaneous requests keep a fixed order.
    always_comb
    begin
        sel_valid = 1'b0;
        sel_idx   = '0;
        for (int s = cuim_pkg::N_SRC - 1; s >= 0; s--)
        begin
            if (pend_ff[s])
            begin
                sel_valid = 1'b1;
                sel_idx   = cuim_pkg::SRC_W'(s);
            end
        end
    end

    // Task number; ranges are not checked against each other.
    always_comb
    begin
        if (sel_idx >= cuim_pkg::SRC_W'(2 * cuim_pkg::N_OUT))
        begin
            sel_task = in_base + cuim_pkg::TASK_W'(sel_idx[0]);  // R10 R14
        end
        else
        begin
            sel_task = out_base + cuim_pkg::TASK_W'(sel_idx);  // R3 R14
        end
    end

    assign fifo_full  = cnt_ff == FIFO_FULL_CNT;
    assign push       = sel_valid && !fifo_full;  // R12
    assign pop        = task_valid && task_ready;
    assign overflow   = |(evt & pend_ff) || (|evt && fifo_full);  // R13
    assign nxt_rd_ptr = pop ? rd_ptr_ff + PTR_ONE : rd_ptr_ff;

    always_comb
    begin
        nxt_pend = pend_ff;
        if (push)
        begin
            nxt_pend[sel_idx] = 1'b0;
        end
        if (!fifo_full)
        begin
            nxt_pend = nxt_pend | evt;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            pat_prev_ff <= '0;
            din_prev_ff <= '0;
        end
        else
        begin
            pat_prev_ff <= output_pattern;
            din_prev_ff <= din;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            pend_ff <= '0;
        end
        else
        begin
            pend_ff <= nxt_pend;  // R12
        end
    end

    // Queue pointers and fill count.
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff    <= '0;
        end
        else
        begin
            rd_ptr_ff <= nxt_rd_ptr;
            if (push)
            begin
                wr_ptr_ff <= wr_ptr_ff + PTR_ONE;
            end
            if (push && !pop)
            begin
                cnt_ff <= cnt_ff + CNT_ONE;
            end
            else if (pop && !push)
            begin
                cnt_ff <= cnt_ff - CNT_ONE;
            end
        end
    end

    cuim_fifo_mem #(
        .WIDTH (cuim_pkg::TASK_W),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_mem (
        .mclk  (mclk),
        .we    (push),
        .waddr (wr_ptr_ff),
        .wdata (sel_task),
        .raddr (nxt_rd_ptr),
        .rdata (task_num)
    );  // R19

    assign task_valid = cnt_ff != '0;

    // Error state; a new overflow wins over the clear command.
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            qfull_err_ff  <= 1'b0;
            qfull_hist_ff <= 1'b0;
        end
        else
        begin
            if (overflow)
            begin
                qfull_err_ff  <= 1'b1;  // R13
                qfull_hist_ff <= 1'b1;  // R15
            end
            else if (clear_cmd)
            begin
                qfull_err_ff <= 1'b0;  // R15
            end
        end
    end

    assign global_error = qfull_err_ff;  // R16

    // Configuration registers.
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            out_ofs_ff    <= cuim_pkg::RST_WORD;
            out_ien_lo_ff <= cuim_pkg::RST_WORD;
            out_ien_hi_ff <= cuim_pkg::RST_WORD;
            in_ofs_ff     <= cuim_pkg::RST_WORD;
            in_ien_ff     <= cuim_pkg::RST_WORD;  // R9
            in_func0_ff   <= cuim_pkg::RST_WORD;
            in_func1_ff   <= cuim_pkg::RST_WORD;
            irq_mask_ff   <= cuim_pkg::RST_IRQ;
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                cuim_pkg::REG_OUT_OFS:    out_ofs_ff    <= reg_wdata;  // R5
                cuim_pkg::REG_OUT_IEN_LO: out_ien_lo_ff <= reg_wdata;  // R18
                cuim_pkg::REG_OUT_IEN_HI: out_ien_hi_ff <= reg_wdata;  // R18
                cuim_pkg::REG_IN_OFS:     in_ofs_ff     <= reg_wdata;
                cuim_pkg::REG_IN_IEN:     in_ien_ff     <= {14'h0000, reg_wdata[1:0]};  // R8
                cuim_pkg::REG_IN_FUNC0:   in_func0_ff   <= reg_wdata;
                cuim_pkg::REG_IN_FUNC1:   in_func1_ff   <= reg_wdata;
                cuim_pkg::REG_IRQ_MASK:   irq_mask_ff   <= reg_wdata[cuim_pkg::IRQ_W-1:0];
                default:
                begin
                end
            endcase
        end
    end

    // Sticky interrupt status; a new event wins over a write-one clear.
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            irq_stat_ff <= cuim_pkg::RST_IRQ;
        end
        else
        begin
            for (int b = 0; b < cuim_pkg::IRQ_W; b++)
            begin
                if (reg_wr && reg_addr == cuim_pkg::REG_IRQ_STAT && reg_wdata[b])
                begin
                    irq_stat_ff[b] <= 1'b0;
                end
            end
            if (push)
            begin
                irq_stat_ff[cuim_pkg::IRQ_BIT_TASK] <= 1'b1;
            end
            if (overflow)
            begin
                irq_stat_ff[cuim_pkg::IRQ_BIT_QFULL] <= 1'b1;
            end
        end
    end

    assign irq = |(irq_stat_ff & irq_mask_ff);

    // Read data stand in the cycle after the read strobe; unmapped addresses read zero.
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            reg_rdata_ff <= cuim_pkg::RST_WORD;
        end
        else if (reg_rd)
        begin
            unique case (reg_addr)
                cuim_pkg::REG_OUT_OFS:    reg_rdata_ff <= out_ofs_ff;
                cuim_pkg::REG_OUT_IEN_LO: reg_rdata_ff <= out_ien_lo_ff;
                cuim_pkg::REG_OUT_IEN_HI: reg_rdata_ff <= out_ien_hi_ff;
                cuim_pkg::REG_IN_OFS:     reg_rdata_ff <= in_ofs_ff;
                cuim_pkg::REG_IN_IEN:     reg_rdata_ff <= in_ien_ff;
                cuim_pkg::REG_IN_FUNC0:   reg_rdata_ff <= in_func0_ff;
                cuim_pkg::REG_IN_FUNC1:   reg_rdata_ff <= in_func1_ff;
                cuim_pkg::REG_IRQ_STAT:   reg_rdata_ff <= 16'(irq_stat_ff);
                cuim_pkg::REG_IRQ_MASK:   reg_rdata_ff <= 16'(irq_mask_ff);
                cuim_pkg::REG_STATUS:
                begin
                    reg_rdata_ff <= cuim_pkg::RST_WORD;
                    reg_rdata_ff[cuim_pkg::ST_GLOBAL_ERR] <= qfull_err_ff;  // R16
                    reg_rdata_ff[cuim_pkg::ST_QFULL_ERR]  <= qfull_err_ff;
                    reg_rdata_ff[cuim_pkg::ST_QFULL_HIST] <= qfull_hist_ff;
                    reg_rdata_ff[cuim_pkg::ST_EMPTY]      <= !task_valid;
                    reg_rdata_ff[cuim_pkg::ST_CNT_LSB +: FIFO_AW+1] <= cnt_ff;
                end
                default:                  reg_rdata_ff <= cuim_pkg::RST_WORD;
            endcase
        end
        else
        begin
            reg_rdata_ff <= cuim_pkg::RST_WORD;
        end
    end

    assign reg_rdata = reg_rdata_ff;
endmodule
